//--- rtl/sdas_pkg.sv
// Notes on behaviour
// [RULE1] effective output is 11-bit signed two's complement
// [RULE2] differential codes span -1024 to +1023
// [RULE3] 13 raw bits, two LSBs for compensation
// [RULE4] power down after 160 idle cycles
// [RULE5] power up takes 40 cycles first
// [RULE6] single-shot converts once then shuts down
// [RULE7] 3-bit input config picks mode and buffering
// [RULE8] separate high and low alarm enables
// [RULE9] reference select split over two registers
// [RULE10] 4-bit input select picks analog source
// [RULE11] continuous select 0 single, 1 continuous
// [RULE12] reference output enable drives reference pin
// [RULE13] configure and start in one write
// [RULE14] go bit starts, holds, clears on completion
// [RULE15] conversion 5129 cycles, plus 40 power-up
// [RULE16] result in high byte and low [7:3]
// [RULE17] completion interrupt only with alarms disabled
// [RULE18] high alarm interrupt above high threshold
// [RULE19] low alarm interrupt below low threshold
// [RULE20] continuous repeats, overwrites result, interrupts each
// [RULE21] go clears after first; result every 256
// [RULE22] thresholds unsigned; negatives low alarm only
// [RULE23] status updated always, hardware sets, write-1 clears
// [RULE24] disabled converter raises no interrupt
// [RULE25] idle counter restarts on activity or request
package sdas_pkg;
   // ----------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------
   localparam logic [4:0] OFF_CTRL0 = 5'h00;
   localparam logic [4:0] OFF_CTRL1 = 5'h04;
   localparam logic [4:0] OFF_RES_HI = 5'h08;
   localparam logic [4:0] OFF_RES_LO = 5'h0c;
   localparam logic [4:0] OFF_THR_HI = 5'h10;
   localparam logic [4:0] OFF_THR_LO = 5'h14;
   localparam logic [4:0] OFF_STATUS = 5'h18;
   // ----------------------------------------------------------
   // field positions
   // ----------------------------------------------------------
   localparam int C0_REFL = 4;
   localparam int C0_REFOUT = 5;
   localparam int C0_REPEAT = 6;
   localparam int C0_GO = 7;
   localparam int C1_HEN = 3;
   localparam int C1_LEN = 4;
   localparam int C1_REFH = 5;
   localparam int C1_HST = 6;
   localparam int C1_LST = 7;
   localparam int ST_PWR = 0;
   localparam int ST_BUSY = 1;
   // ----------------------------------------------------------
   // reset values and timing counts, in system clock cycles
   // ----------------------------------------------------------
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] THR_HI_RST = 8'hff;
   localparam logic [7:0] THR_LO_RST = 8'h00;
   localparam int CONV_CYCLES_DEF = 5129;
   localparam int PWRUP_CYCLES = 40;
   localparam int IDLE_PD_CYCLES = 160;
   localparam int REPEAT_PERIOD = 256;
   localparam int CNT_W = 16;
   localparam int RES_W = 13;
   // ----------------------------------------------------------
   // sequencer states
   // ----------------------------------------------------------
   typedef enum logic [1:0] {
      SDAS_IDLE,
      SDAS_PWRUP,
      SDAS_CONV
   } sdas_state_t;
endpackage

//--- rtl/sdas_sequencer.sv
`timescale 1ns/10ps
module sdas_sequencer
   import sdas_pkg::*;
#(
   parameter int CONV_CYCLES = CONV_CYCLES_DEF
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [12:0] conv_data,
   output logic analog_power_up,
   output logic conv_active,
   output logic [3:0] input_select_field,
   output logic [2:0] input_config_field,
   output logic [1:0] reference_select,
   output logic reference_out_enable,
   output logic adc_irq
);

   // ----------------------------------------------------------
   // state record
   // ----------------------------------------------------------
   typedef struct packed {
      sdas_state_t state;
      logic [CNT_W-1:0] cnt;
      logic [7:0] idle_cnt;
      logic pwr;
      logic active;
      logic [3:0] in_sel;
      logic ref_lo;
      logic ref_out;
      logic rpt;
      logic go;
      logic [2:0] in_cfg;
      logic hen;
      logic len;
      logic ref_hi;
      logic hst;
      logic lst;
      logic [7:0] res_hi;
      logic [7:0] res_lo;
      logic [7:0] thr_hi;
      logic [7:0] thr_lo;
      logic done;
      logic irq;
      logic wreq;
      logic [31:0] rdata;
   } sdas_regs_t;

   localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES - 1);
   localparam logic [CNT_W-1:0] PWRUP_LAST = CNT_W'(PWRUP_CYCLES - 1);
   localparam logic [CNT_W-1:0] REPEAT_LAST = CNT_W'(REPEAT_PERIOD - 1);
   localparam logic [7:0] IDLE_LAST = 8'(IDLE_PD_CYCLES - 1);

   sdas_regs_t s_q;
   sdas_regs_t s_d;

   logic fire;
   logic wr_ctrl0;
   logic wr_ctrl1;
   logic start_req;
   logic finish;
   logic hi_hit;
   logic lo_hit;
   logic [7:0] wbyte;

   // ----------------------------------------------------------
   // bus decode helpers
   // ----------------------------------------------------------
   assign fire = (avs_read | avs_write) & ~s_q.wreq;
   assign wbyte = avs_writedata[7:0];
   assign wr_ctrl0 = fire & avs_write & avs_byteenable[0] & (avs_address == OFF_CTRL0);
   assign wr_ctrl1 = fire & avs_write & avs_byteenable[0] & (avs_address == OFF_CTRL1);
   // go written in the same write that configures the channel
   assign start_req = wr_ctrl0 & wbyte[C0_GO]; // RULE13
   assign finish = (s_q.state == SDAS_CONV) && (s_q.cnt == '0);
   // thresholds compare against the eight bits below the sign
   assign hi_hit = ~conv_data[12] & (conv_data[11:4] > s_q.thr_hi); // RULE22
   assign lo_hit = conv_data[12] | (conv_data[11:4] < s_q.thr_lo); // RULE22

   // ----------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------
   always_comb begin
      s_d = s_q;
      if (ce) begin
         s_d.done = 1'b0;
         s_d.irq = 1'b0;
         // one wait cycle per access, then waitrequest drops
         s_d.wreq = ~((avs_read | avs_write) & s_q.wreq);
         if (avs_read & s_q.wreq) begin
            s_d.rdata = 32'h0;
            unique case (avs_address)
               OFF_CTRL0: s_d.rdata[7:0] = {s_q.go, s_q.rpt, s_q.ref_out, s_q.ref_lo,
                                            s_q.in_sel};
               OFF_CTRL1: s_d.rdata[7:0] = {s_q.lst, s_q.hst, s_q.ref_hi, s_q.len,
                                            s_q.hen, s_q.in_cfg};
               OFF_RES_HI: s_d.rdata[7:0] = s_q.res_hi;
               OFF_RES_LO: s_d.rdata[7:0] = s_q.res_lo;
               OFF_THR_HI: s_d.rdata[7:0] = s_q.thr_hi;
               OFF_THR_LO: s_d.rdata[7:0] = s_q.thr_lo;
               OFF_STATUS: s_d.rdata[ST_BUSY:ST_PWR] = {s_q.active, s_q.pwr};
               default: s_d.rdata = 32'h0;
            endcase
         end
         // configuration writes
         if (wr_ctrl0) begin
            s_d.in_sel = wbyte[3:0]; // RULE10
            s_d.ref_lo = wbyte[C0_REFL]; // RULE9
            s_d.ref_out = wbyte[C0_REFOUT]; // RULE12
            s_d.rpt = wbyte[C0_REPEAT]; // RULE11
         end
         if (wr_ctrl1) begin
            s_d.in_cfg = wbyte[2:0]; // RULE7
            s_d.hen = wbyte[C1_HEN]; // RULE8
            s_d.len = wbyte[C1_LEN]; // RULE8
            s_d.ref_hi = wbyte[C1_REFH]; // RULE9
            // alarm status is write-one-to-clear
            if (wbyte[C1_HST]) begin
               s_d.hst = 1'b0; // RULE23
            end
            if (wbyte[C1_LST]) begin
               s_d.lst = 1'b0; // RULE23
            end
         end
         if (fire & avs_write & avs_byteenable[0] & (avs_address == OFF_THR_HI)) begin
            s_d.thr_hi = wbyte;
         end
         if (fire & avs_write & avs_byteenable[0] & (avs_address == OFF_THR_LO)) begin
            s_d.thr_lo = wbyte;
         end
         // sequencer
         unique case (s_q.state)
            SDAS_IDLE: begin
               if (start_req) begin
                  s_d.go = 1'b1; // RULE14
                  s_d.active = 1'b1;
                  if (s_q.pwr) begin
                     s_d.state = SDAS_CONV;
                     s_d.cnt = CONV_LAST; // RULE15
                  end else begin
                     s_d.state = SDAS_PWRUP;
                     s_d.cnt = PWRUP_LAST; // RULE5
                  end
               end
            end
            SDAS_PWRUP: begin
               if (s_q.cnt == '0) begin
                  s_d.pwr = 1'b1; // RULE5
                  s_d.state = SDAS_CONV;
                  s_d.cnt = CONV_LAST; // RULE15
               end else begin
                  s_d.cnt = s_q.cnt - 1'b1;
               end
            end
            SDAS_CONV: begin
               if (finish) begin
                  // 13 raw bits: 11 effective plus two compensation bits
                  s_d.res_hi = conv_data[12:5]; // RULE1 RULE2 RULE3 RULE16 RULE20
                  s_d.res_lo = {conv_data[4:0], 3'h0}; // RULE16
                  s_d.go = 1'b0; // RULE14 RULE21
                  s_d.done = 1'b1;
                  // interrupt only leaves while the converter is running
                  s_d.irq = (~s_q.hen & ~s_q.len) // RULE17 RULE24
                     | (s_q.hen & hi_hit) // RULE18
                     | (s_q.len & lo_hit); // RULE19
                  if (s_q.rpt & ~(wr_ctrl0 & ~wbyte[C0_REPEAT])) begin
                     s_d.cnt = REPEAT_LAST; // RULE20 RULE21
                  end else begin
                     s_d.state = SDAS_IDLE; // RULE6
                     s_d.active = 1'b0;
                  end
               end else begin
                  s_d.cnt = s_q.cnt - 1'b1;
               end
            end
            default: s_d.state = SDAS_IDLE;
         endcase
         // set wins over a write-one clear in the same cycle
         if (finish & hi_hit) begin
            s_d.hst = 1'b1; // RULE23
         end
         if (finish & lo_hit) begin
            s_d.lst = 1'b1; // RULE23
         end
         // idle run counter and automatic power-down
         if (s_q.state != SDAS_IDLE || start_req || !s_q.pwr) begin
            s_d.idle_cnt = 8'h0; // RULE25
         end else if (s_q.idle_cnt == IDLE_LAST) begin
            s_d.pwr = 1'b0; // RULE4
            s_d.idle_cnt = 8'h0;
         end else begin
            s_d.idle_cnt = s_q.idle_cnt + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------
   // state register
   // ----------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         s_q <= '{state: SDAS_IDLE, cnt: '0, idle_cnt: 8'h0, pwr: 1'b0, active: 1'b0,
                  in_sel: 4'h0, ref_lo: 1'b0, ref_out: 1'b0, rpt: 1'b0, go: 1'b0,
                  in_cfg: 3'h0, hen: 1'b0, len: 1'b0, ref_hi: 1'b0, hst: 1'b0,
                  lst: 1'b0, res_hi: CTRL_RST, res_lo: CTRL_RST, thr_hi: THR_HI_RST,
                  thr_lo: THR_LO_RST, done: 1'b0, irq: 1'b0, wreq: 1'b1,
                  rdata: 32'h0};
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------
   // outputs, all straight from the state record
   // ----------------------------------------------------------
   assign avs_readdata = s_q.rdata;
   assign avs_waitrequest = s_q.wreq;
   assign analog_power_up = s_q.pwr;
   assign conv_active = s_q.active;
   assign input_select_field = s_q.in_sel;
   assign input_config_field = s_q.in_cfg;
   assign reference_select = {s_q.ref_hi, s_q.ref_lo};
   assign reference_out_enable = s_q.ref_out;
   assign adc_irq = s_q.irq;

   // ----------------------------------------------------------
   // assertions
   // ----------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn || !ce);

   property p_power_down;
      (s_q.state == SDAS_IDLE) && s_q.pwr && (s_q.idle_cnt == IDLE_LAST) && !start_req
         |=> !s_q.pwr;
   endproperty
   a_power_down: assert property (p_power_down) else $error("no power-down after idle run"); // RULE4

   property p_pwrup_entry;
      (s_q.state == SDAS_IDLE) && !s_q.pwr && start_req
         |=> (s_q.state == SDAS_PWRUP) && (s_q.cnt == PWRUP_LAST) && s_q.go;
   endproperty
   a_pwrup_entry: assert property (p_pwrup_entry) else $error("power-up not entered"); // RULE5

   property p_pwrup_exit;
      (s_q.state == SDAS_PWRUP) && (s_q.cnt == '0)
         |=> (s_q.state == SDAS_CONV) && (s_q.cnt == CONV_LAST) && s_q.pwr;
   endproperty
   a_pwrup_exit: assert property (p_pwrup_exit) else $error("conversion not begun"); // RULE15

   property p_go_held;
      (s_q.state == SDAS_CONV) && !finish && s_q.go |=> s_q.go;
   endproperty
   a_go_held: assert property (p_go_held) else $error("go bit dropped early"); // RULE14

   property p_single_end;
      finish && !s_q.rpt
         |=> (s_q.state == SDAS_IDLE) && !s_q.go && s_q.done && !s_q.active;
   endproperty
   a_single_end: assert property (p_single_end) else $error("single shot did not stop"); // RULE6

   property p_repeat_next;
      finish && s_q.rpt && !wr_ctrl0
         |=> (s_q.state == SDAS_CONV) && (s_q.cnt == REPEAT_LAST) && !s_q.go;
   endproperty
   a_repeat_next: assert property (p_repeat_next) else $error("continuous period wrong"); // RULE21

   property p_result;
      finish |=> ({s_q.res_hi, s_q.res_lo} == {$past(conv_data), 3'h0});
   endproperty
   a_result: assert property (p_result) else $error("result not placed"); // RULE16

   property p_irq_cause;
      s_q.irq |-> s_q.done && ((!s_q.hen && !s_q.len) || (s_q.hen && s_q.hst)
         || (s_q.len && s_q.lst));
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("interrupt without cause"); // RULE24

   property p_irq_complete;
      finish && !s_q.hen && !s_q.len |=> s_q.irq;
   endproperty
   a_irq_complete: assert property (p_irq_complete) else $error("no completion irq"); // RULE17

   property p_negative_low;
      finish && conv_data[12] |=> s_q.lst;
   endproperty
   a_negative_low: assert property (p_negative_low) else $error("negative missed low"); // RULE22

   property p_w1c;
      s_q.hst && wr_ctrl1 && wbyte[C1_HST] && !(finish && hi_hit) |=> !s_q.hst;
   endproperty
   a_w1c: assert property (p_w1c) else $error("high status not cleared"); // RULE23

   // ----------------------------------------------------------
   // bus handshake, counters and interrupt sources
   // ----------------------------------------------------------
   property p_wait_one;
      (avs_read || avs_write) && s_q.wreq |=> !s_q.wreq;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("waitrequest did not drop");

   property p_wait_back;
      !s_q.wreq |=> s_q.wreq;
   endproperty
   a_wait_back: assert property (p_wait_back) else $error("waitrequest low too long");

   property p_idle_restart;
      (s_q.state != SDAS_IDLE) |=> (s_q.idle_cnt == 8'h0);
   endproperty
   a_idle_restart: assert property (p_idle_restart) else $error("idle count kept"); // RULE25

   property p_busy_powered;
      (s_q.state == SDAS_CONV) |=> s_q.pwr;
   endproperty
   a_busy_powered: assert property (p_busy_powered) else $error("power lost in use"); // RULE4

   property p_pwrup_count;
      (s_q.state == SDAS_PWRUP) && (s_q.cnt != '0)
         |=> (s_q.state == SDAS_PWRUP) && (s_q.cnt == $past(s_q.cnt) - 1'b1);
   endproperty
   a_pwrup_count: assert property (p_pwrup_count) else $error("power-up count wrong"); // RULE5

   property p_go_start;
      (s_q.state == SDAS_IDLE) && start_req |=> s_q.go && s_q.active;
   endproperty
   a_go_start: assert property (p_go_start) else $error("go not set on start"); // RULE14

   property p_sel_copy;
      wr_ctrl0 |=> (s_q.in_sel == $past(wbyte[3:0]));
   endproperty
   a_sel_copy: assert property (p_sel_copy) else $error("input select not taken"); // RULE10

   property p_hi_status;
      finish && hi_hit |=> s_q.hst;
   endproperty
   a_hi_status: assert property (p_hi_status) else $error("high status not set"); // RULE23

   property p_hi_irq;
      finish && s_q.hen && hi_hit |=> s_q.irq;
   endproperty
   a_hi_irq: assert property (p_hi_irq) else $error("no high alarm irq"); // RULE18

   property p_lo_irq;
      finish && s_q.len && lo_hit |=> s_q.irq;
   endproperty
   a_lo_irq: assert property (p_lo_irq) else $error("no low alarm irq"); // RULE19

   property p_alarm_mask;
      finish && (s_q.hen || s_q.len) && !(s_q.hen && hi_hit)
         && !(s_q.len && lo_hit)
         |=> !s_q.irq;
   endproperty
   a_alarm_mask: assert property (p_alarm_mask) else $error("completion irq not masked"); // RULE17

   property p_irq_pulse;
      s_q.irq |=> !s_q.irq;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt longer than a pulse"); // RULE24

   // main scenarios
   c_single: cover property (finish && !s_q.rpt);
   c_repeat: cover property (s_q.done && (s_q.state == SDAS_CONV));
   c_pwrup: cover property ((s_q.state == SDAS_PWRUP) && (s_q.cnt == '0));
   c_pdown: cover property ($fell(s_q.pwr));

endmodule // sdas_sequencer

//--- bench/tb.sv
`timescale 1ns/10ps
module tb;
   import sdas_pkg::*;
   localparam int CONV = 20;
   logic core_clk;
   logic resetn;
   logic ce_i;
   logic [4:0] addr;
   logic rd;
   logic wr;
   logic [31:0] wdata;
   logic [3:0] be;
   logic [31:0] rdata;
   logic wreq;
   logic [12:0] conv_data;
   logic pwr;
   logic act;
   logic [3:0] sel;
   logic [2:0] cfg;
   logic [1:0] rsel;
   logic rout;
   logic irq;
   logic [31:0] rv;
   int error_cnt;
   int n_tests;
   int n;
   time t0;

   sdas_sequencer #(.CONV_CYCLES(CONV)) dut_u (.core_clk(core_clk), .resetn(resetn),
      .ce(ce_i), .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
      .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wreq),
      .conv_data(conv_data), .analog_power_up(pwr), .conv_active(act),
      .input_select_field(sel), .input_config_field(cfg), .reference_select(rsel),
      .reference_out_enable(rout), .adc_irq(irq));

   // ----------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------
   task automatic end_of_test();
      if (error_cnt == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s exp %h got %h", nm, e, g);
      end
   endtask

   // one avalon access, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                      input logic [3:0] b);
      int k;
      @(posedge core_clk);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= {24'h0, d};
      be <= b;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (wreq !== 1'h0 && k < 50);
      if (k >= 50) error_cnt++;
      rv = rdata;
      rd <= 1'h0;
      wr <= 1'h0;
   endtask

   // edges from t0 until the interrupt pulse is seen, or lim edges
   task automatic wait_irq(input int lim);
      int k;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (irq !== 1'h1 && k < lim);
      n = (irq === 1'h1) ? int'(($time - t0) / 20) : 0;
   endtask

   // ----------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------
   task automatic t_reset();
      chk("pwr", 32'h0, pwr);
      bus(1'h0, OFF_THR_HI, 8'h0, 4'hf);
      chk("thr_hi", THR_HI_RST, rv);
      bus(1'h1, OFF_THR_HI, 8'h12, 4'he);
      bus(1'h0, OFF_THR_HI, 8'h0, 4'hf);
      chk("be0", THR_HI_RST, rv);
      bus(1'h0, 5'h1c, 8'h0, 4'hf);
      chk("unmapped", 32'h0, rv);
   endtask

   // single shot from power-down, configured and started in one write
   task automatic t_single();
      conv_data <= 13'h1abd;
      bus(1'h1, OFF_CTRL1, 8'h25, 4'h1);
      bus(1'h1, OFF_CTRL0, 8'hb9, 4'h1);
      t0 = $time;
      bus(1'h0, OFF_CTRL0, 8'h0, 4'hf);
      chk("go", 32'hb9, rv);
      chk("cfg", 32'h5, cfg);
      chk("sel", 32'h9, sel);
      chk("rsel", 32'h3, rsel);
      chk("rout", 32'h1, rout);
      chk("act", 32'h1, act);
      // clock enable low for ten edges stretches the sequence by ten
      ce_i <= 1'h0;
      repeat (10) @(posedge core_clk);
      ce_i <= 1'h1;
      wait_irq(200);
      chk("t_pwrup", PWRUP_CYCLES + CONV + 11, n);
      bus(1'h0, OFF_CTRL0, 8'h0, 4'hf);
      chk("go_clr", 32'h39, rv);
      bus(1'h0, OFF_STATUS, 8'h0, 4'hf);
      chk("status", 32'h1, rv);
      bus(1'h0, OFF_RES_HI, 8'h0, 4'hf);
      chk("res_hi", 32'hd5, rv);
      bus(1'h0, OFF_RES_LO, 8'h0, 4'hf);
      chk("res_lo", 32'he8, rv);
   endtask

   // one powered conversion with alarm settings; irq time and status
   task automatic alarm(input logic hen, input logic len, input logic [12:0] d,
                        input logic [7:0] thi, input logic [7:0] tlo,
                        input logic ei, input logic [1:0] es);
      conv_data <= d;
      bus(1'h1, OFF_THR_HI, thi, 4'h1);
      bus(1'h1, OFF_THR_LO, tlo, 4'h1);
      bus(1'h1, OFF_CTRL1, {3'h7, len, hen, 3'h5}, 4'h1);
      bus(1'h1, OFF_CTRL0, 8'hb9, 4'h1);
      t0 = $time;
      wait_irq(CONV + 4);
      chk("irq", ei ? CONV + 1 : 0, n);
      bus(1'h0, OFF_CTRL1, 8'h0, 4'hf);
      chk("alarm_st", {24'h0, es, 1'h1, len, hen, 3'h5}, rv);
   endtask

   task automatic t_alarms();
      alarm(1'h0, 1'h0, 13'h0500, 8'h40, 8'h10, 1'h1, 2'h1);
      alarm(1'h1, 1'h0, 13'h0500, 8'h50, 8'h10, 1'h0, 2'h0);
      alarm(1'h1, 1'h0, 13'h0510, 8'h50, 8'h10, 1'h1, 2'h1);
      alarm(1'h1, 1'h0, 13'h1f00, 8'h50, 8'h10, 1'h0, 2'h2);
      alarm(1'h0, 1'h1, 13'h0100, 8'h50, 8'h10, 1'h0, 2'h0);
      alarm(1'h0, 1'h1, 13'h00f0, 8'h50, 8'h10, 1'h1, 2'h2);
      alarm(1'h1, 1'h1, 13'h0300, 8'h50, 8'h10, 1'h0, 2'h0);
   endtask

   // continuous run, stop, then idle power-down
   task automatic t_repeat();
      int m;
      conv_data <= 13'h0200;
      bus(1'h1, OFF_CTRL1, 8'hc5, 4'h1);
      bus(1'h1, OFF_CTRL0, 8'hc9, 4'h1);
      t0 = $time;
      wait_irq(CONV + 4);
      chk("first", CONV + 1, n);
      conv_data <= 13'h0ab8;
      t0 = $time;
      wait_irq(REPEAT_PERIOD + 4);
      chk("period", REPEAT_PERIOD, n);
      bus(1'h0, OFF_CTRL0, 8'h0, 4'hf);
      chk("go_rep", 32'h49, rv);
      bus(1'h0, OFF_RES_HI, 8'h0, 4'hf);
      chk("res_new", 32'h55, rv);
      bus(1'h1, OFF_CTRL0, 8'h09, 4'h1);
      m = 0;
      while (act !== 1'h0 && m < 600) begin
         @(posedge core_clk);
         m++;
      end
      m = 0;
      while (pwr !== 1'h0 && m < 400) begin
         @(posedge core_clk);
         m++;
      end
      chk("pd_time", 32'h1, m >= IDLE_PD_CYCLES - 1 && m <= IDLE_PD_CYCLES + 1);
      t0 = $time;
      wait_irq(300);
      chk("idle_irq", 32'h0, n);
   endtask

   // ----------------------------------------------------------
   // clock, watchdog and main sequence
   // ----------------------------------------------------------
   initial begin
      core_clk = 1'h0;
      forever #10 core_clk = ~core_clk;
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      error_cnt++;
      end_of_test();
   end

   initial begin
      resetn = 1'h0;
      ce_i = 1'h1;
      rd = 1'h0;
      wr = 1'h0;
      addr = 5'h0;
      wdata = 32'h0;
      be = 4'h0;
      conv_data = 13'h0;
      error_cnt = 0;
      n_tests = 0;
      repeat (4) @(posedge core_clk);
      resetn <= 1'h1;
      t_reset();
      t_single();
      t_alarms();
      t_repeat();
      end_of_test();
   end
endmodule // tb
